//--- logic/eeprom_ctrl_pkg.sv
// Constants and types for the data EEPROM access controller
package eeprom_ctrl_pkg;

  localparam int AXI_AW = 14;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_LOC  = 12'h0F7E;
  localparam logic [11:0] IDX_DAT  = 12'h0F80;
  localparam logic [11:0] IDX_CON1 = 12'h0F81;
  localparam logic [11:0] IDX_KEY  = 12'h0F82;
  localparam logic [11:0] IDX_DONE = 12'h0F84;
  localparam logic [11:0] IDX_CFG  = 12'h0F85;

  // Control, configuration and done register fields
  localparam int CON1_RD     = 0;
  localparam int CON1_WR     = 1;
  localparam int CON1_PERMIT = 2;
  localparam int CON1_FAULT  = 3;
  localparam int CON1_REG_LO = 6;
  localparam int CON1_REG_HI = 7;
  localparam int CFG_CODE_PROT = 0;
  localparam int CFG_WR_PROT   = 1;
  localparam int DONE_BIT      = 0;

  localparam logic [1:0] REGION_EEPROM = 2'h0;
  localparam logic [1:0] REGION_FLASH  = 2'h2;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 4_000_000;
  localparam int PWRT_TIME_NS  = 64_000_000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES   = PWRT_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2} key_state_type;

endpackage

//--- logic/data_eeprom_access_controller.sv
// Data EEPROM access controller with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
module data_eeprom_access_controller
  import eeprom_ctrl_pkg::*;
#(
  parameter int DEPTH      = 1024,
  parameter int PROG_COUNT = PROG_CYCLES,
  parameter int PWRT_COUNT = PWRT_CYCLES
) (
  input  wire logic                              I_CLOCK,
  input  wire logic                              I_RST,
  input  wire logic                              I_POR,
  input  wire logic                              I_AWVALID,
  output logic                                   O_AWREADY,
  input  wire logic [eeprom_ctrl_pkg::AXI_AW-1:0] I_AWADDR,
  input  wire logic                              I_WVALID,
  output logic                                   O_WREADY,
  input  wire logic [31:0]                       I_WDATA,
  input  wire logic [3:0]                        I_WSTRB,
  output logic                                   O_BVALID,
  input  wire logic                              I_BREADY,
  output logic [1:0]                             O_BRESP,
  input  wire logic                              I_ARVALID,
  output logic                                   O_ARREADY,
  input  wire logic [eeprom_ctrl_pkg::AXI_AW-1:0] I_ARADDR,
  output logic                                   O_RVALID,
  input  wire logic                              I_RREADY,
  output logic [31:0]                            O_RDATA,
  output logic [1:0]                             O_RRESP,
  output logic                                   O_WRITE_BUSY,
  output logic                                   O_DONE_FLAG
);
  import eeprom_ctrl_pkg::*;

  localparam int PCW = $clog2(PROG_COUNT + 1);
  localparam int TCW = $clog2(PWRT_COUNT + 1);

  typedef struct packed {
    logic              aw_have;
    logic [AXI_AW-1:0] awaddr;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [9:0]        loc;
    logic [7:0]        dat;
    logic [1:0]        region;
    logic              fault;
    logic              permit;
    logic              wr;
    logic              rd;
    logic              done;
    logic              code_prot;
    logic              wr_prot;
    key_state_type     key;
    logic [PCW-1:0]    prog_cnt;
    logic [TCW-1:0]    pwrt_cnt;
    logic              first;
  } state_type;

  state_type   st_ff;
  state_type   nxt_st;
  logic [7:0]  mem [DEPTH];
  logic [7:0]  mem_rd;
  logic        mem_we;
  logic        busy_shadow_ff;
  logic [11:0] widx;
  logic [11:0] ridx;
  logic [1:0]  new_region;
  logic        loc_ok;

  assign loc_ok = 32'(st_ff.loc) < DEPTH;
  assign mem_rd = loc_ok ? mem[st_ff.loc] : 8'h00;
  assign mem_we = st_ff.wr && (st_ff.prog_cnt == PCW'(1));
  assign widx   = st_ff.awaddr[AXI_AW-1:2];
  assign ridx   = I_ARADDR[AXI_AW-1:2];

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    new_region = st_ff.wdata[CON1_REG_HI:CON1_REG_LO];

    // Address and data channels, taken in either order
    if (I_AWVALID && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = I_AWADDR;
      nxt_st.awready = 1'b0;
    end
    if (I_WVALID && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = I_WDATA;
      nxt_st.wstrb  = I_WSTRB;
      nxt_st.wready = 1'b0;
    end
    if (st_ff.bvalid && I_BREADY) begin
      nxt_st.bvalid  = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready  = 1'b1;
    end

    // Register write effects
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = RESP_OKAY;
      // Any write other than a key discards a partial unlock
      nxt_st.key     = KEY_IDLE;
      unique case (widx)
        IDX_LOC: begin
          if (!st_ff.wr && st_ff.wstrb[0]) begin
            nxt_st.loc[7:0] = st_ff.wdata[7:0];
          end
          if (!st_ff.wr && st_ff.wstrb[1]) begin
            nxt_st.loc[9:8] = st_ff.wdata[9:8];
          end
        end
        IDX_DAT: begin
          if (!st_ff.wr && st_ff.wstrb[0]) begin
            nxt_st.dat = st_ff.wdata[7:0];
          end
        end
        IDX_CON1: begin
          if (!st_ff.wr && st_ff.wstrb[0]) begin
            nxt_st.region = new_region;
            nxt_st.permit = st_ff.wdata[CON1_PERMIT];
            nxt_st.fault  = st_ff.wdata[CON1_FAULT];
            // Only the EEPROM region reads here; flash is refused
            if (st_ff.wdata[CON1_RD] && new_region == REGION_EEPROM
                && new_region != REGION_FLASH) begin
              nxt_st.rd = 1'b1;
            end
            // Permit must already be set: same write cannot enable it
            if (st_ff.wdata[CON1_WR] && st_ff.permit
                && st_ff.key == KEY_GOT2) begin
              if (new_region != REGION_EEPROM || st_ff.code_prot
                  || st_ff.wr_prot || !loc_ok) begin
                nxt_st.fault = 1'b1;
              end else if (st_ff.pwrt_cnt == '0) begin
                nxt_st.wr       = 1'b1;
                nxt_st.fault    = 1'b1;
                nxt_st.prog_cnt = PCW'(PROG_COUNT);
              end
            end
          end
        end
        IDX_KEY: begin
          if (st_ff.wstrb[0]) begin
            if (st_ff.wdata[7:0] == KEY_FIRST) begin
              nxt_st.key = KEY_GOT1;
            end else if (st_ff.wdata[7:0] == KEY_SECOND
                         && st_ff.key == KEY_GOT1) begin
              nxt_st.key = KEY_GOT2;
            end
          end
        end
        IDX_DONE: begin
          if (st_ff.wstrb[0] && !st_ff.wdata[DONE_BIT]) begin
            nxt_st.done = 1'b0;
          end
        end
        IDX_CFG: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.code_prot = st_ff.wdata[CFG_CODE_PROT];
            nxt_st.wr_prot   = st_ff.wdata[CFG_WR_PROT];
          end
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (I_ARVALID && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid  = 1'b1;
      nxt_st.rresp   = RESP_OKAY;
      nxt_st.rdata   = 32'h0000_0000;
      unique case (ridx)
        IDX_LOC:  nxt_st.rdata[9:0] = st_ff.loc;
        IDX_DAT:  nxt_st.rdata[7:0] = st_ff.dat;
        IDX_CON1: begin
          nxt_st.rdata[CON1_REG_HI:CON1_REG_LO] = st_ff.region;
          nxt_st.rdata[CON1_FAULT]  = st_ff.fault;
          nxt_st.rdata[CON1_PERMIT] = st_ff.permit;
          nxt_st.rdata[CON1_WR]     = st_ff.wr;
          nxt_st.rdata[CON1_RD]     = st_ff.rd;
        end
        IDX_KEY:  nxt_st.rdata = 32'h0000_0000;
        IDX_DONE: nxt_st.rdata[DONE_BIT] = st_ff.done;
        IDX_CFG: begin
          nxt_st.rdata[CFG_CODE_PROT] = st_ff.code_prot;
          nxt_st.rdata[CFG_WR_PROT]   = st_ff.wr_prot;
        end
        default:  nxt_st.rresp = RESP_SLVERR;
      endcase
    end
    if (st_ff.rvalid && I_RREADY) begin
      nxt_st.rvalid  = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // Array read: one cycle after the strobe; code protection blocks it
    if (st_ff.rd) begin
      nxt_st.rd = 1'b0;
      if (!st_ff.code_prot) begin
        nxt_st.dat = mem_rd;
      end
    end

    // Self-timed write; hardware events after bus so set wins
    if (st_ff.wr) begin
      if (mem_we) begin
        nxt_st.wr    = 1'b0;
        nxt_st.fault = 1'b0;
        nxt_st.done  = 1'b1;
      end else begin
        nxt_st.prog_cnt = st_ff.prog_cnt - PCW'(1);
      end
    end

    if (st_ff.pwrt_cnt != '0) begin
      nxt_st.pwrt_cnt = st_ff.pwrt_cnt - TCW'(1);
    end

    nxt_st.first = 1'b0;
    if (st_ff.first && busy_shadow_ff) begin
      nxt_st.fault = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      st_ff          <= '0;
      st_ff.awready  <= 1'b1;
      st_ff.wready   <= 1'b1;
      st_ff.arready  <= 1'b1;
      st_ff.key      <= KEY_IDLE;
      st_ff.pwrt_cnt <= TCW'(PWRT_COUNT);
      st_ff.first    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Survives the warm reset so an interrupted write can be reported
  always_ff @(posedge I_CLOCK) begin
    if (I_POR) begin
      busy_shadow_ff <= 1'b0;
    end else if (!I_RST) begin
      busy_shadow_ff <= st_ff.wr;
    end
  end

  // Byte write overwrites whole byte: erase is implicit
  always_ff @(posedge I_CLOCK) begin
    if (mem_we) begin
      mem[st_ff.loc] <= st_ff.dat;
    end
  end

  assign O_AWREADY    = st_ff.awready;
  assign O_WREADY     = st_ff.wready;
  assign O_BVALID     = st_ff.bvalid;
  assign O_BRESP      = st_ff.bresp;
  assign O_ARREADY    = st_ff.arready;
  assign O_RVALID     = st_ff.rvalid;
  assign O_RDATA      = st_ff.rdata;
  assign O_RRESP      = st_ff.rresp;
  assign O_WRITE_BUSY = st_ff.wr;
  assign O_DONE_FLAG  = st_ff.done;

endmodule

//--- tb/eeprom_ctrl_asserts.sv
// Port-level assertions for the data EEPROM access controller
module eeprom_ctrl_asserts
  import eeprom_ctrl_pkg::*;
#(
  parameter int PROG_COUNT = 20
) (
  input wire logic                               I_CLOCK,
  input wire logic                               I_RST,
  input wire logic                               I_AWVALID,
  input wire logic                               O_AWREADY,
  input wire logic [eeprom_ctrl_pkg::AXI_AW-1:0] I_AWADDR,
  input wire logic                               I_WVALID,
  input wire logic                               O_WREADY,
  input wire logic                               O_BVALID,
  input wire logic                               I_BREADY,
  input wire logic                               I_ARVALID,
  input wire logic                               O_ARREADY,
  input wire logic [eeprom_ctrl_pkg::AXI_AW-1:0] I_ARADDR,
  input wire logic                               O_RVALID,
  input wire logic                               I_RREADY,
  input wire logic [31:0]                        O_RDATA,
  input wire logic                               O_WRITE_BUSY,
  input wire logic                               O_DONE_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] A_CON1 = {IDX_CON1, 2'b00};
  localparam logic [13:0] A_KEY  = {IDX_KEY, 2'b00};
  localparam logic [13:0] A_DONE = {IDX_DONE, 2'b00};
  logic [31:0] busy_cnt_ff;

  // Cycles the write strobe has been seen high so far
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) busy_cnt_ff <= '0;
    else busy_cnt_ff <= O_WRITE_BUSY ? busy_cnt_ff + 32'h0000_0001 : '0;
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  chk_busy_length: assert property ($fell(O_WRITE_BUSY) |->
    busy_cnt_ff == PROG_COUNT) else $error("write length wrong");
  chk_busy_bound: assert property (busy_cnt_ff <= PROG_COUNT)
    else $error("write runs too long");
  chk_done_at_end: assert property ($fell(O_WRITE_BUSY) |-> O_DONE_FLAG)
    else $error("done flag not set at write end");
  chk_done_sticky: assert property ($fell(O_DONE_FLAG) |->
    I_AWADDR == A_DONE) else $error("done flag dropped by itself");
  chk_start_by_ctrl: assert property ($rose(O_WRITE_BUSY) |->
    I_AWADDR == A_CON1) else $error("write began without strobe");
  chk_key_zero: assert property (O_RVALID && I_ARADDR == A_KEY |->
    O_RDATA == 32'h0000_0000) else $error("key register not zero");
  chk_b_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |-> ##2 O_BVALID) else $error("write response late");
  chk_b_single: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  chk_r_answer: assert property (I_ARVALID && O_ARREADY |=>
    O_RVALID && !O_ARREADY) else $error("read data late");
  chk_r_single: assert property (O_RVALID && I_RREADY |=>
    !O_RVALID && O_ARREADY) else $error("read data repeated");

  cover property ($fell(O_WRITE_BUSY));
  cover property ($fell(O_DONE_FLAG));
  cover property (O_RVALID && I_ARADDR == A_KEY);
endmodule

bind data_eeprom_access_controller eeprom_ctrl_asserts #(
  .PROG_COUNT(PROG_COUNT)
) i_eeprom_ctrl_asserts (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
  .O_WRITE_BUSY(O_WRITE_BUSY), .O_DONE_FLAG(O_DONE_FLAG)
);

//--- tb/data_eeprom_access_controller_bench.sv
// Self-checking bench for the data EEPROM access controller
module data_eeprom_access_controller_bench;
  import eeprom_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] A_LOC  = {IDX_LOC, 2'b00};
  localparam logic [13:0] A_DAT  = {IDX_DAT, 2'b00};
  localparam logic [13:0] A_CON1 = {IDX_CON1, 2'b00};
  localparam logic [13:0] A_KEY  = {IDX_KEY, 2'b00};
  localparam logic [13:0] A_DONE = {IDX_DONE, 2'b00};
  localparam logic [13:0] A_CFG  = {IDX_CFG, 2'b00};
  localparam int          PWRT   = 40;
  logic        clk, rst, por, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy, done;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          error_cnt, total_checks;

  data_eeprom_access_controller #(.DEPTH(1024), .PROG_COUNT(20),
    .PWRT_COUNT(PWRT)) i_data_eeprom_access_controller (
    .I_CLOCK(clk), .I_RST(rst), .I_POR(por), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
    .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_WRITE_BUSY(busy), .O_DONE_FLAG(done));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Handshakes judged at the falling edge, where the flops are settled
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(negedge clk);
      if (awvalid && awready) aw_t = 1'b1;
      if (wvalid && wready) w_t = 1'b1;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a);
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    v = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic unlock_go;
    wr(A_KEY, {24'h00_0000, KEY_FIRST});
    wr(A_KEY, {24'h00_0000, KEY_SECOND});
    wr(A_CON1, 32'h0000_0006);
  endtask

  task automatic t_powerup;
    rd(A_CON1);
    chk(v & 32'h0000_0007, 32'h0000_0000);
    wr(A_CON1, 32'h0000_0004);
    unlock_go;
    chkf(busy, 1'b0);
    repeat (PWRT) @(posedge clk);
  endtask

  task automatic t_write;
    wr(A_LOC, 32'h0000_03A5);
    wr(A_DAT, 32'h0000_005C);
    unlock_go;
    chkf(busy, 1'b1);
    rd(A_CON1);
    chk(v & 32'h0000_000E, 32'h0000_000E);
    wr(A_DAT, 32'h0000_0011);
    wr(A_CON1, 32'h0000_0000);
    while (busy) @(negedge clk);
    chkf(done, 1'b1);
    rd(A_CON1);
    chk(v & 32'h0000_000E, 32'h0000_0004);
    rd(A_LOC);
    chk(v, 32'h0000_03A5);
    rd(A_DAT);
    chk(v, 32'h0000_005C);
  endtask

  task automatic t_read;
    wr(A_DAT, 32'h0000_0000);
    wr(A_CON1, 32'h0000_0005);
    rd(A_DAT);
    chk(v, 32'h0000_005C);
    rd(A_CON1);
    chk(v & 32'h0000_0001, 32'h0000_0000);
    wr(A_DONE, 32'h0000_0000);
    chkf(done, 1'b0);
  endtask

  task automatic t_refuse;
    wr(A_DAT, 32'h0000_0000);
    wr(A_CON1, 32'h0000_0085);
    wr(A_CON1, 32'h0000_0045);
    rd(A_DAT);
    chk(v, 32'h0000_0000);
    wr(A_CON1, 32'h0000_0004);
    wr(A_KEY, {24'h00_0000, KEY_FIRST});
    wr(A_DAT, 32'h0000_0077);
    wr(A_KEY, {24'h00_0000, KEY_SECOND});
    wr(A_CON1, 32'h0000_0006);
    chkf(busy, 1'b0);
    rd(A_KEY);
    chk(v, 32'h0000_0000);
    rd(14'h0100);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(A_CFG, 32'h0000_0001);
    wr(A_DAT, 32'h0000_0000);
    wr(A_CON1, 32'h0000_0005);
    rd(A_DAT);
    chk(v, 32'h0000_0000);
    unlock_go;
    chkf(busy, 1'b0);
    wr(A_CON1, 32'h0000_0004);
    wr(A_CFG, 32'h0000_0002);
    unlock_go;
    chkf(busy, 1'b0);
    rd(A_CON1);
    chk(v & 32'h0000_000A, 32'h0000_0008);
    wr(A_CON1, 32'h0000_0004);
    rd(A_CON1);
    chk(v & 32'h0000_0008, 32'h0000_0000);
  endtask

  task automatic t_reset_mid;
    wr(A_CFG, 32'h0000_0000);
    wr(A_DAT, 32'h0000_00FF);
    unlock_go;
    chkf(busy, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(A_CON1);
    chk(v & 32'h0000_0008, 32'h0000_0008);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 14'h0000; araddr = 14'h0000; wdata = '0; wstrb = 4'hF;
    error_cnt = 0; total_checks = 0; rst = 1'b1; por = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_powerup;
    t_write;
    t_read;
    t_refuse;
    t_reset_mid;
    report_and_stop;
  end
endmodule
